/* common/pixel_format_defs.vh */
// Purpose: Constants for the pixel format path control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Printed indices are word indices, not byte addresses; byte address = 4*index
`ifndef PIXEL_FORMAT_DEFS_VH
`define PIXEL_FORMAT_DEFS_VH

// Register indices and byte addresses
`define IDX_SIXTEEN_CTL 8'h0C
`define IDX_PACKED_CTL 8'h0D
`define IDX_PIXEL_FORMAT 8'h0A
`define IDX_OVERLAY_CTL 8'h0F
`define IDX_LANE_STATUS 8'h10
`define ADDR_SIXTEEN_CTL 12'h030
`define ADDR_PACKED_CTL 12'h034
`define ADDR_PIXEL_FORMAT 12'h028
`define ADDR_OVERLAY_CTL 12'h03C
`define ADDR_LANE_STATUS 12'h040

// Pixel format codes
`define FMT_SIXTEEN 3'h4
`define FMT_PACKED 3'h5

// Sixteen-bit control fields
`define S16_DCOL_HI 7
`define S16_DCOL_LO 6
`define S16_POL 5
`define S16_MODE_HI 4
`define S16_MODE_LO 3
`define S16_FILL 2
`define S16_WIDTH 1
`define S16_ORDER 1
`define S16_SPACE 0

// Format codes and path codes
`define MODE_RGB 2'h0
`define MODE_TAG87 2'h1
`define MODE_YUV 2'h2
`define MODE_TAG78 2'h3
`define DCOL_INDIRECT 2'h0
`define DCOL_DYNAMIC 2'h1
`define DCOL_DIRECT 2'h3

// Packed control fields
`define PK_SPACE 7
`define PK_PATH 0

// Overlay control fields
`define OV_KEY 0
`define OV_PATH 1

// Per-lane path codes
`define PATH_LOOKUP 2'h0
`define PATH_BYPASS 2'h1
`define PATH_YUV 2'h2
`define PATH_GREY 2'h3

`define LANES 4
`define APB_ERR_NONE 1'b0

`endif

/* rtl/pixel_lane_decode.v */
// Purpose: Decodes one 16-bit pixel lane into path, colour or luma/chroma
// Assumes: Control bits stable for the pixel; combinational
// Notes: One instance per lane, so tag and bypass stay per pixel
`include "pixel_format_defs.vh"

module pixel_lane_decode (
    input wire [15:0] pix,
    input wire [7:0] ctl,
    input wire keyMatch,
    input wire overlayGrey,
    output reg [1:0] path,
    output reg [23:0] color,
    output reg [7:0] luma,
    output reg [7:0] chroma
);
    reg [1:0] mode;
    reg [1:0] dcol;
    reg isYuv;
    reg wide;
    reg fill;
    reg [4:0] r5;
    reg [5:0] g6;
    reg [4:0] b5;
    reg bypass;
    reg contig;

    always @* begin
        mode = ctl[`S16_MODE_HI:`S16_MODE_LO];
        dcol = ctl[`S16_DCOL_HI:`S16_DCOL_LO];
        isYuv = 1'b0;
        wide = 1'b0;
        fill = 1'b0;
        bypass = 1'b0;
        contig = ctl[`S16_SPACE];
        luma = 8'h00;
        chroma = 8'h00;
        path = `PATH_LOOKUP;
        case (mode)
            `MODE_RGB: begin
                if (dcol == `DCOL_DYNAMIC) begin
                    // Top bit steers per pixel; polarity flips it
                    bypass = pix[15] ^ ctl[`S16_POL];
                    // Dynamic bypass forces sparse indexing
                    contig = 1'b0;
                end else begin
                    bypass = (dcol == `DCOL_DIRECT);
                    wide = ctl[`S16_WIDTH];
                    fill = ctl[`S16_FILL];
                end
            end
            `MODE_YUV: begin
                isYuv = 1'b1;
                // Field order for subsampled layout
                luma = ctl[`S16_ORDER] ? pix[7:0] : pix[15:8];
                chroma = ctl[`S16_ORDER] ? pix[15:8] : pix[7:0];
            end
            default: begin
                // Tagged layouts: tag is the top bit
                isYuv = pix[15] ^ ctl[`S16_POL];
                if (isYuv) begin
                    if (mode == `MODE_TAG87) begin
                        luma = ctl[`S16_ORDER] ? {pix[6:0], 1'b0}
                            : pix[14:7];
                        chroma = ctl[`S16_ORDER] ? pix[14:7]
                            : {pix[6:0], 1'b0};
                    end else begin
                        luma = ctl[`S16_ORDER] ? pix[7:0]
                            : {pix[14:8], 1'b0};
                        chroma = ctl[`S16_ORDER] ? {pix[14:8], 1'b0}
                            : pix[7:0];
                    end
                end else begin
                    // Order bit unused here
                    bypass = (dcol == `DCOL_DIRECT);
                    fill = ctl[`S16_FILL];
                end
            end
        endcase
        if (isYuv) begin
            // Overlay path only matters under key matching
            // Grey overlay belongs to the plain YUV layout only
            path = (mode == `MODE_YUV && keyMatch && overlayGrey)
                ? `PATH_GREY
                : `PATH_YUV;
        end else if (bypass) begin
            path = `PATH_BYPASS;
        end
        r5 = pix[14:10];
        g6 = wide ? pix[10:5] : {pix[9:5], 1'b0};
        b5 = pix[4:0];
        if (wide) begin
            r5 = pix[15:11];
        end
        color = 24'h000000;
        if (!isYuv) begin
            if (bypass) begin
                // Low-bit fill on expansion
                color[23:16] = {r5, fill ? r5[4:2] : 3'h0};
                if (wide) begin
                    color[15:8] = {g6, fill ? g6[5:4] : 2'h0};
                end else begin
                    color[15:8] = {g6[5:1], fill ? g6[5:3] : 3'h0};
                end
                color[7:0] = {b5, fill ? b5[4:2] : 3'h0};
            end else if (contig) begin
                // Contiguous index: fill ignored
                color[23:16] = {3'h0, r5};
                color[15:8] = wide ? {2'h0, g6} : {3'h0, g6[5:1]};
                color[7:0] = {3'h0, b5};
            end else begin
                // Sparse index: zero fill expected from software
                color[23:16] = {r5, 3'h0};
                color[15:8] = wide ? {g6, 2'h0} : {g6[5:1], 3'h0};
                color[7:0] = {b5, 3'h0};
            end
        end
    end
endmodule // pixel_lane_decode

/* rtl/pixel_format_path_control.v */
// Purpose: Pixel format decode and palette path selection
// Assumes: APB slave, 20 MHz clock, pixel words from frame buffer
// Notes: Palette, colour matrix and converters live elsewhere
//
// Functional notes
// - Polarity bit inverts per-pixel bypass meaning
// - Polarity used in dynamic bypass and tag decode
// - Fill zero or replicate high bits
// - Contiguous indexing ignores fill setting
// - Width bit picks 555 or 565
// - Spacing bit: 0 sparse, 1 contiguous
// - Format field selects tagged or YUV layouts
// - Tagged RGB path: 00 lookup, 11 bypass
// - RGB path field ignored for YUV
// - Top bit tag, polarity flips meaning
// - 8+7 order bit places luma, chroma
// - Subsampled YUV order bit swaps bytes
// - 7+8 order bit places luma, chroma
// - Fill and spacing ignored for YUV
// - Order bit ignored for RGB pixels
// - Overlay path: palette or grey under key
// - Packed RGB: 8-8-8, bit 0 path
// - Packed YUV bypasses palette, bit 0 ignored
// - Packed path bit only in RGB
// - Dynamic bypass uses top bit per pixel
//
// Local design decision: the APB interface to the registers.
`include "pixel_format_defs.vh"

module pixel_format_path_control (
    input wire clock,
    input wire srst,
    input wire clkEn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [63:0] pixIn,
    input wire pixValid,
    output reg [63:0] pixColor,
    output reg [7:0] pixPath,
    output reg [31:0] pixLuma,
    output reg [31:0] pixChroma,
    output reg pixOutValid,
    output reg [31:0] packedColor,
    output reg [1:0] packedPath,
    output reg [7:0] overlayColor,
    output reg [1:0] overlayPath
);
    // Reset values are undefined in the part; zero chosen for safety
    reg [7:0] sixteenCtl_r;
    reg [7:0] packedCtl_r;
    reg [2:0] pixelFormat_r;
    reg [1:0] overlayCtl_r;
    reg [7:0] laneStatus_r;
    reg [31:0] rdata_nxt;
    reg hit;

    wire [95:0] laneColor;
    wire [63:0] laneColorLow;
    wire [7:0] lanePath;
    wire [31:0] laneLuma;
    wire [31:0] laneChroma;

    ////////////////////////////////////////////////////////////////////
    // Register bus
    wire setup = psel && !penable;
    wire access = psel && penable && pready;

    always @* begin
        hit = 1'b1;
        rdata_nxt = 32'h00000000;
        case (paddr)
            `ADDR_SIXTEEN_CTL: rdata_nxt = {24'h000000, sixteenCtl_r};
            `ADDR_PACKED_CTL: rdata_nxt = {24'h000000, packedCtl_r};
            `ADDR_PIXEL_FORMAT: rdata_nxt = {29'h00000000, pixelFormat_r};
            `ADDR_OVERLAY_CTL: rdata_nxt = {30'h00000000, overlayCtl_r};
            `ADDR_LANE_STATUS: rdata_nxt = {24'h000000, laneStatus_r};
            default: hit = 1'b0;
        endcase
    end

    // No wait state: pready rises the cycle after setup
    always @(posedge clock) begin
        if (srst) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            sixteenCtl_r <= 8'h00;
            packedCtl_r <= 8'h00;
            pixelFormat_r <= 3'h0;
            overlayCtl_r <= 2'h0;
        end else if (clkEn) begin
            pready <= setup;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rdata_nxt;
                pslverr <= !hit;
            end else if (access) begin
                pslverr <= `APB_ERR_NONE;
            end
            if (access && pwrite && hit) begin
                case (paddr)
                    `ADDR_SIXTEEN_CTL: sixteenCtl_r <= pwdata[7:0];
                    `ADDR_PACKED_CTL: packedCtl_r <= pwdata[7:0];
                    `ADDR_PIXEL_FORMAT: pixelFormat_r <= pwdata[2:0];
                    `ADDR_OVERLAY_CTL: overlayCtl_r <= pwdata[1:0];
                    default: packedCtl_r <= packedCtl_r;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-lane decode
    genvar g;
    generate
        for (g = 0; g < `LANES; g = g + 1) begin : lane
            // Own tag and bypass bit per lane
            pixel_lane_decode u_dec (
                .pix(pixIn[16*g+15:16*g]),
                .ctl(sixteenCtl_r),
                .keyMatch(overlayCtl_r[`OV_KEY]),
                .overlayGrey(overlayCtl_r[`OV_PATH]),
                .path(lanePath[2*g+1:2*g]),
                .color(laneColor[24*g+23:24*g]),
                .luma(laneLuma[8*g+7:8*g]),
                .chroma(laneChroma[8*g+7:8*g])
            );
            // Bus carries low 16 bits of each expanded colour
            assign laneColorLow[16*g+15:16*g] = laneColor[24*g+15:24*g];
        end
    endgenerate

    // One register stage for all lanes keeps one driver per output
    always @(posedge clock) begin
        if (srst) begin
            pixColor <= 64'h0000000000000000;
            pixPath <= {`LANES{`PATH_LOOKUP}};
            pixLuma <= 32'h00000000;
            pixChroma <= 32'h00000000;
            laneStatus_r <= {`LANES{`PATH_LOOKUP}};
        end else if (clkEn && pixValid) begin
            pixColor <= laneColorLow;
            pixPath <= lanePath;
            pixLuma <= laneLuma;
            pixChroma <= laneChroma;
            laneStatus_r <= lanePath;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Packed 24-bit and overlay paths
    wire packedYuv = packedCtl_r[`PK_SPACE];
    wire [1:0] packedPath_nxt = packedYuv ? `PATH_YUV
        : (packedCtl_r[`PK_PATH] ? `PATH_BYPASS
        : `PATH_LOOKUP);
    wire [1:0] ovPath_nxt = overlayCtl_r[`OV_PATH] ? `PATH_GREY
        : `PATH_LOOKUP;

    always @(posedge clock) begin
        if (srst) begin
            pixOutValid <= 1'b0;
            packedColor <= 32'h00000000;
            packedPath <= `PATH_LOOKUP;
            overlayColor <= 8'h00;
            overlayPath <= `PATH_LOOKUP;
        end else if (clkEn) begin
            pixOutValid <= pixValid;
            if (pixValid) begin
                // Low 24 bits are R,G,B or Y,U,V; top byte overlay
                packedColor <= {8'h00, pixIn[23:0]};
                packedPath <= (pixelFormat_r == `FMT_PACKED)
                    ? packedPath_nxt : `PATH_LOOKUP;
                overlayColor <= pixIn[31:24];
                // Overlay path only live under key matching
                overlayPath <= overlayCtl_r[`OV_KEY] ? ovPath_nxt
                    : `PATH_LOOKUP;
            end
        end
    end
endmodule // pixel_format_path_control

/* sim/pixel_format_checker_assertions.sv */
// Purpose: Port-level checks on the pixel format path control
// Assumes: One clock, synchronous active-high reset
// Notes: Register state is hidden, so checks tie outputs to inputs
module pixel_format_checker (
    input wire clock,
    input wire srst,
    input wire clkEn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    input wire [63:0] pixIn,
    input wire pixValid,
    input wire pixOutValid,
    input wire [31:0] packedColor,
    input wire [1:0] packedPath,
    input wire [1:0] overlayPath
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    property p_ack; psel && !penable && clkEn |=> pready; endproperty
    property p_pulse; pready && clkEn |=> !pready; endproperty
    property p_err; pready && pslverr |-> prdata == 32'h0; endproperty
    property p_hold;
        !pready && !(psel && !penable)
            |=> $stable(prdata) && $stable(pslverr);
    endproperty
    property p_valid; clkEn |=> pixOutValid == $past(pixValid); endproperty
    property p_ovl; overlayPath == 2'h0 || overlayPath == 2'h3; endproperty
    property p_pkpath; packedPath != 2'h3; endproperty
    property p_pkcol;
        pixOutValid && $past(clkEn)
            |-> packedColor == {8'h00, $past(pixIn[23:0])};
    endproperty
    a_ack: assert property (p_ack)
        else $error("no pready after setup");
    a_pulse: assert property (p_pulse)
        else $error("pready longer than one cycle");
    a_err: assert property (p_err)
        else $error("refused read returned data");
    a_hold: assert property (p_hold)
        else $error("read data moved outside a transfer");
    a_valid: assert property (p_valid)
        else $error("pixel valid delay wrong");
    a_ovl: assert property (p_ovl)
        else $error("overlay path code illegal");
    a_pkpath: assert property (p_pkpath)
        else $error("packed path code illegal");
    a_pkcol: assert property (p_pkcol)
        else $error("packed colour not the low 24 bits");
    c_err: cover property (pready && pslverr);
    c_grey: cover property (overlayPath == 2'h3);
    c_pkyuv: cover property (packedPath == 2'h2);
endmodule // pixel_format_checker

bind pixel_format_path_control pixel_format_checker u_chk (
    .clock(clock), .srst(srst), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pixIn(pixIn), .pixValid(pixValid), .pixOutValid(pixOutValid),
    .packedColor(packedColor), .packedPath(packedPath),
    .overlayPath(overlayPath));

/* sim/frame_buffer_model.sv */
// Purpose: Frame buffer stand-in supplying pixel words
// Assumes: Words change just after the rising edge
// Notes: Idle bus toggles every cycle, so stale words never look valid
module frame_buffer_model (
    input wire clock,
    input wire run,
    output logic [63:0] pixIn,
    output logic pixValid
);
    timeunit 1ns;
    timeprecision 1ns;
    integer seed = 6;
    initial pixIn = 64'h0;
    initial pixValid = 1'b0;
    // Random gaps stall the stream like a busy memory
    always @(posedge clock) begin
        if (run && ($random(seed) & 3) != 0) begin
            pixIn <= {$random(seed), $random(seed)};
            pixValid <= 1'b1;
        end else begin
            pixIn <= ~pixIn;
            pixValid <= 1'b0;
        end
    end
endmodule // frame_buffer_model

/* sim/tb_pixel_format_path_control.sv */
// Purpose: Self-checking bench for the pixel format path control
// Assumes: 20 MHz clock, APB master, frame buffer model
// Notes: Controls change only while the pixel stream is idle
`include "pixel_format_defs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_pixel_format_path_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, srst = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, packedColor, pixLuma, pixChroma, q;
    logic [63:0] pixIn, pixColor, lastPix;
    logic [7:0] pixPath, overlayColor, c16 = 0, pk = 0;
    logic [1:0] packedPath, overlayPath, ov = 0;
    logic [2:0] fmt = 0;
    logic pready, pslverr, pixValid, pixOutValid, run = 0, e;
    logic [7:0] corner [7] = '{8'h40, 8'h60, 8'hC6, 8'hC2,
        8'h2A, 8'h3A, 8'h12};
    logic [7:0] st;
    integer seed = 6, checked = 0, miscompares = 0;
    always #25 clock = ~clock;
    pixel_format_path_control DUT (.clock(clock), .srst(srst), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pixIn(pixIn), .pixValid(pixValid), .pixColor(pixColor),
        .pixPath(pixPath), .pixLuma(pixLuma), .pixChroma(pixChroma),
        .pixOutValid(pixOutValid), .packedColor(packedColor),
        .packedPath(packedPath), .overlayColor(overlayColor),
        .overlayPath(overlayPath));
    frame_buffer_model fb (.clock(clock), .run(run), .pixIn(pixIn),
        .pixValid(pixValid));
    ////////////////////////////////////////////////////////////////////////
    function automatic [1:0] expPath(input [7:0] c, input [15:0] p);
        if (c[4:3] == `MODE_YUV) expPath = `PATH_YUV;
        else if (c[4:3] != 2'h0 && (p[15] ^ c[5]))
            expPath = `PATH_YUV;
        else if (c[4:3] != 2'h0) expPath = {1'h0, c[7]};
        else if (c[7:6] == 2'h1) expPath = {1'h0, p[15] ^ c[5]};
        else expPath = {1'h0, c[7]};
    endfunction
    function automatic [1:0] expLane(input [7:0] c, input [1:0] o,
        input [15:0] p);
        expLane = expPath(c, p);
        if (c[4:3] == `MODE_YUV && o == 2'h3) expLane = `PATH_GREY;
    endfunction
    function automatic [15:0] expYc(input [7:0] c, input [15:0] p);
        case (c[4:3])
            2'h1: expYc = c[1] ? {p[6:0], 1'h0, p[14:7]}
                : {p[14:7], p[6:0], 1'h0};
            2'h2: expYc = c[1] ? {p[7:0], p[15:8]} : p;
            default: expYc = c[1] ? {p[7:0], p[14:8], 1'h0}
                : {p[14:8], 1'h0, p[7:0]};
        endcase
    endfunction
    // Tagged RGB is always 555, so the shared order bit must not widen it
    function automatic [15:0] expCol(input [7:0] c, input [15:0] p);
        logic f;
        f = c[2];
        expCol[7:0] = {p[4:0], f ? p[4:2] : 3'h0};
        if (c[1] && c[4:3] == 2'h0)
            expCol[15:8] = {p[10:5], f ? p[10:9] : 2'h0};
        else expCol[15:8] = {p[9:5], f ? p[9:7] : 3'h0};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // pready rising ends this wait; the watchdog ends it only if pready never comes
        while (pready !== 1'b1) @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so psel is never set twice in one step
        @(posedge clock);
    endtask
    task automatic check_word(input logic [63:0] w);
        logic [15:0] p, v;
        logic [1:0] x;
        if (fmt == `FMT_PACKED) begin
            x = pk[7] ? `PATH_YUV : {1'h0, pk[0]};
            `CHK("packedPath", x, packedPath)
            `CHK("packedColor", {8'h00, w[23:0]}, packedColor)
        end else begin
            x = ov == 2'h3 ? 2'h3 : 2'h0;
            if (c16[4:3] == `MODE_YUV) begin
                `CHK("overlayPath", x, overlayPath)
            end
            for (int g = 0; g < 4; g++) begin
                p = w[16*g +: 16];
                x = expPath(c16, p);
                if (x == `PATH_YUV) begin
                    v = {pixLuma[8*g +: 8], pixChroma[8*g +: 8]};
                    `CHK("yc", expYc(c16, p), v)
                end else if (x == `PATH_BYPASS && c16[7:6] == 2'h3) begin
                    `CHK("color", expCol(c16, p), pixColor[16*g +: 16])
                end
                x = expLane(c16, ov, p);
                `CHK("pixPath", x, pixPath[2*g +: 2])
            end
        end
        `CHK("overlayColor", w[31:24], overlayColor)
    endtask
    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        if (pixValid && clkEn && !srst) lastPix <= pixIn;
        if (pixOutValid === 1'b1 && !srst) check_word(lastPix);
    end
    initial begin
        #250000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        apb(0, `ADDR_SIXTEEN_CTL, 0);
        `CHK("ctlReset", 32'h0, q)
        apb(1, `ADDR_PACKED_CTL, 32'h1A5);
        apb(0, `ADDR_PACKED_CTL, 0);
        `CHK("upperZero", 32'hA5, q)
        apb(0, 12'h0F8, 0);
        `CHK("unmapped", 1'b1, e)
        `CHK("refusedData", 32'h0, q)
        // No double buffering here, so either width is legal
        for (int i = 0; i < 30; i++) begin
            c16 = i < 7 ? corner[i] : $random(seed);
            if (c16[7:6] == 2'h2) c16[7:6] = 2'h3;
            if (!c16[0] && c16[7:6] != 2'h3) c16[2] = 1'b0;
            pk = $random(seed);
            ov = $random(seed);
            fmt = i[0] ? `FMT_PACKED : `FMT_SIXTEEN;
            apb(1, `ADDR_SIXTEEN_CTL, {24'h0, c16});
            apb(1, `ADDR_PACKED_CTL, {24'h0, pk});
            apb(1, `ADDR_OVERLAY_CTL, {30'h0, ov});
            apb(1, `ADDR_PIXEL_FORMAT, {29'h0, fmt});
            apb(0, `ADDR_SIXTEEN_CTL, 0);
            `CHK("sixteenCtl", {24'h0, c16}, q)
            run <= 1'b1;
            repeat (40) begin
                @(posedge clock);
                // Random stalls show that clkEn freezes the stream
                clkEn <= ($random(seed) & 7) != 0;
            end
            run <= 1'b0;
            clkEn <= 1'b1;
            repeat (3) @(posedge clock);
            for (int g = 0; g < 4; g++)
                st[2*g +: 2] = expLane(c16, ov, lastPix[16*g +: 16]);
            apb(0, `ADDR_LANE_STATUS, 0);
            `CHK("laneStatus", {24'h0, st}, q)
        end
        report_and_stop();
    end
endmodule // tb_pixel_format_path_control
